// file: rtl/lle_defines.svh
// Constants for the ladder logic executor
`ifndef LLE_DEFINES_SVH
`define LLE_DEFINES_SVH
`define LLE_CLK_HZ       25000000
`define LLE_TIMEBASE_MS  100
`define LLE_PC_W         8
`define LLE_STACK_DEPTH  8
`define LLE_BLOCK_DEPTH  8
`define LLE_NUM_Y        16
`define LLE_NUM_M        32
`define LLE_NUM_BITS     48
`define LLE_NUM_TC       16
`define LLE_NUM_REG      10
`define LLE_REG_A_IDX    8
`define LLE_REG_B_IDX    9
`define LLE_PC_RESET     8'h00
`endif

// file: rtl/lle_pkg.sv
// Types for the ladder logic executor
package lle_pkg;
    typedef enum logic [3:0] {
        LLE_OP_NOP   = 4'h0,
        LLE_OP_BEGIN = 4'h1,
        LLE_OP_BEGNI = 4'h2,
        LLE_OP_JOIN  = 4'h3,
        LLE_OP_PUSH  = 4'h4,
        LLE_OP_PEEK  = 4'h5,
        LLE_OP_POP   = 4'h6,
        LLE_OP_COIL  = 4'h7,
        LLE_OP_SET   = 4'h8,
        LLE_OP_CLR   = 4'h9,
        LLE_OP_TMR   = 4'ha,
        LLE_OP_TALLY = 4'hb,
        LLE_OP_END   = 4'hc
    } lle_op_type;
    typedef enum logic [2:0] {
        LLE_OT_X = 3'h0,
        LLE_OT_Y = 3'h1,
        LLE_OT_M = 3'h2,
        LLE_OT_T = 3'h3,
        LLE_OT_C = 3'h4,
        LLE_OT_D = 3'h5,
        LLE_OT_A = 3'h6,
        LLE_OT_B = 3'h7
    } lle_otype_type;
    typedef struct packed {
        lle_op_type    op;
        logic          dbl;
        lle_otype_type otype;
        logic [4:0]    addr;
        logic [31:0]   kval;
    } lle_instr_type;
endpackage : lle_pkg

// file: rtl/lle_executor.sv
// Ladder logic execution unit: one instruction per clock
`timescale 1ns/1ps
`include "lle_defines.svh"
module lle_executor #(
    parameter int TICK_CYCLES = `LLE_TIMEBASE_MS * (`LLE_CLK_HZ / 1000)
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire lle_pkg::lle_instr_type instr,
    input  wire logic [15:0]           x_in,
    input  wire logic                  in_handler,
    output logic [`LLE_PC_W-1:0]       pc_r,
    output logic [15:0]                y_out_r,
    output logic [`LLE_NUM_BITS-1:0]   pulse_r,
    output logic [`LLE_NUM_REG-1:0]    reg_clr_r,
    output logic                       stack_err_r
);
    import lle_pkg::*;

    // State
    logic                     acc_r;
    logic                     acc_nxt;
    logic [`LLE_NUM_BITS-1:0] ym_r;
    logic                     rstk_r [`LLE_STACK_DEPTH];
    logic [3:0]               rsp_r;
    logic [3:0]               rsp_nxt;
    logic                     bstk_r [`LLE_BLOCK_DEPTH];
    logic [2:0]               bsp_r;
    logic [2:0]               bsp_nxt;
    logic [15:0]              tmr_val_r [`LLE_NUM_TC];
    logic [`LLE_NUM_TC-1:0]   tmr_on_r;
    logic [`LLE_NUM_TC-1:0]   tick_pend_r;
    logic [31:0]              cnt_val_r [`LLE_NUM_TC];
    logic [`LLE_NUM_TC-1:0]   cnt_on_r;
    logic [`LLE_NUM_TC-1:0]   cnt_prev_r;
    logic [`LLE_PC_W-1:0]     pos_r [`LLE_NUM_BITS];
    logic [21:0]              tick_cnt_r;
    logic                     err_set;

    // Decode of the current instruction
    wire lle_op_type    op      = instr.op;
    wire lle_otype_type ot      = instr.otype;
    wire [3:0]          ti      = instr.addr[3:0];
    wire [5:0]          w_idx   = (ot == LLE_OT_Y) ? {2'b00, ti}
                                                   : 6'(16 + instr.addr);
    wire                ot_bit  = (ot == LLE_OT_Y) || (ot == LLE_OT_M);
    wire                is_end  = (op == LLE_OP_END);
    wire                is_clr  = (op == LLE_OP_CLR) && acc_r;

    // Contact value of the operand, coils and timers read back here
    wire contact = (ot == LLE_OT_X) ? x_in[ti] :
                   ot_bit           ? ym_r[w_idx] :
                   (ot == LLE_OT_T) ? tmr_on_r[ti] :
                   (ot == LLE_OT_C) ? cnt_on_r[ti] : 1'b0;

    // Bit writes: coil follows result, set latches on, clear latches off
    wire wr_en  = ot_bit && ((op == LLE_OP_COIL) ||
                  ((op == LLE_OP_SET) && acc_r) ||
                  is_clr);
    wire wr_val = (op == LLE_OP_COIL) ? acc_r : (op == LLE_OP_SET);

    // Timer step for the addressed timer
    wire        tmr_sel  = (op == LLE_OP_TMR);
    wire [15:0] tmr_cur  = tmr_val_r[ti];
    wire        tmr_step = acc_r && tick_pend_r[ti] && (tmr_cur < instr.kval[15:0]);
    wire [15:0] tmr_nxt  = !acc_r ? 16'h0000 :
                           tmr_step ? 16'(tmr_cur + 16'h0001) : tmr_cur;

    // Counter step, 16-bit form masks value and preset
    wire        cnt_sel  = (op == LLE_OP_TALLY);
    wire [31:0] cnt_cur  = cnt_val_r[ti];
    wire [31:0] cnt_pre  = instr.dbl ? instr.kval : {16'h0000, instr.kval[15:0]};
    wire        cnt_rise = acc_r && !cnt_prev_r[ti];
    wire [31:0] cnt_inc  = instr.dbl ? 32'(cnt_cur + 32'h0000_0001)
                                     : {16'h0000, 16'(cnt_cur[15:0] + 16'h0001)};
    wire [31:0] cnt_nxt  = (cnt_rise && (cnt_cur < cnt_pre)) ? cnt_inc : cnt_cur;

    // Timebase tick
    wire tick = (tick_cnt_r == 22'(TICK_CYCLES - 1));

    // Result, result stack and block stack next values
    always_comb begin
        acc_nxt = acc_r;
        rsp_nxt = rsp_r;
        bsp_nxt = bsp_r;
        err_set = 1'b0;
        case (op)
            LLE_OP_BEGIN, LLE_OP_BEGNI: begin
                acc_nxt = contact ^ (op == LLE_OP_BEGNI);
                bsp_nxt = 3'(bsp_r + 3'h1);
            end
            LLE_OP_JOIN: begin
                acc_nxt = acc_r | bstk_r[3'(bsp_r - 3'h1)];
                bsp_nxt = 3'(bsp_r - 3'h1);
            end
            LLE_OP_PUSH: begin
                if (rsp_r == 4'(`LLE_STACK_DEPTH)) begin
                    err_set = 1'b1;
                end else begin
                    rsp_nxt = 4'(rsp_r + 4'h1);
                end
            end
            LLE_OP_PEEK, LLE_OP_POP: begin
                if (rsp_r == 4'h0) begin
                    err_set = 1'b1;
                end else begin
                    acc_nxt = rstk_r[3'(rsp_r - 4'h1)];
                    if (op == LLE_OP_POP) begin
                        rsp_nxt = 4'(rsp_r - 4'h1);
                    end
                end
            end
            LLE_OP_END: begin
                rsp_nxt = 4'h0;
                bsp_nxt = 3'h0;
            end
            default: begin
                acc_nxt = acc_r;
            end
        endcase
    end

    // Result register and stack pointers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_r       <= 1'b0;
            rsp_r       <= 4'h0;
            bsp_r       <= 3'h0;
            stack_err_r <= 1'b0;
        end else begin
            acc_r       <= acc_nxt;
            rsp_r       <= rsp_nxt;
            bsp_r       <= bsp_nxt;
            stack_err_r <= stack_err_r | err_set;
        end
    end

    // Stack storage; the block entry saves the result a new chain replaces
    always_ff @(posedge clock) begin
        if ((op == LLE_OP_PUSH) && !err_set) begin
            rstk_r[rsp_r[2:0]] <= acc_r;
        end
        if ((op == LLE_OP_BEGIN) || (op == LLE_OP_BEGNI)) begin
            bstk_r[bsp_r] <= acc_r;
        end
    end

    // Step counter; frozen while a handler runs, wraps at end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pc_r    <= `LLE_PC_RESET;
            y_out_r <= 16'h0000;
        end else if (!in_handler) begin
            pc_r <= is_end ? `LLE_PC_RESET : `LLE_PC_W'(pc_r + 1'b1);
            if (is_end) begin
                y_out_r <= ym_r[15:0];
            end
        end
    end

    // Output and relay image
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ym_r <= '0;
        end else if (wr_en) begin
            ym_r[w_idx] <= wr_val;
        end
    end

    // Pulse component per bit, kept one scan from the changing line
    genvar g;
    generate
        for (g = 0; g < `LLE_NUM_BITS; g++) begin : g_pulse
            wire rise = wr_en && (w_idx == 6'(g)) && wr_val && !ym_r[g];
            wire fall = wr_en && (w_idx == 6'(g)) && !wr_val;
            wire done = !in_handler && (pos_r[g] == pc_r);
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    pulse_r[g] <= 1'b0;
                    pos_r[g]   <= `LLE_PC_RESET;
                end else if (rise) begin
                    pulse_r[g] <= 1'b1;
                    pos_r[g]   <= pc_r;
                end else if (fall || done) begin
                    pulse_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Timebase divider and per-timer pending ticks; a tick beats the consume
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_cnt_r  <= 22'h00_0000;
            tick_pend_r <= '0;
        end else begin
            tick_cnt_r  <= tick ? 22'h00_0000 : 22'(tick_cnt_r + 22'h00_0001);
            tick_pend_r <= {`LLE_NUM_TC{tick}} |
                           (tick_pend_r & ~(`LLE_NUM_TC'(tmr_sel) << ti));
        end
    end

    // Timers: count toward preset while enabled, clear on drop or clear op
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tmr_on_r <= '0;
            for (int i = 0; i < `LLE_NUM_TC; i++) begin
                tmr_val_r[i] <= 16'h0000;
            end
        end else if (tmr_sel) begin
            tmr_val_r[ti] <= tmr_nxt;
            tmr_on_r[ti]  <= acc_r && (tmr_nxt >= instr.kval[15:0]);
        end else if (is_clr && (ot == LLE_OT_T)) begin
            tmr_val_r[ti] <= 16'h0000;
            tmr_on_r[ti]  <= 1'b0;
        end
    end

    // Counters: rising input steps value, contact on at preset until cleared
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_on_r   <= '0;
            cnt_prev_r <= '0;
            for (int i = 0; i < `LLE_NUM_TC; i++) begin
                cnt_val_r[i] <= 32'h0000_0000;
            end
        end else if (cnt_sel) begin
            cnt_val_r[ti]  <= cnt_nxt;
            cnt_prev_r[ti] <= acc_r;
            cnt_on_r[ti]   <= cnt_nxt >= cnt_pre;
        end else if (is_clr && (ot == LLE_OT_C)) begin
            cnt_val_r[ti] <= 32'h0000_0000;
            cnt_on_r[ti]  <= 1'b0;
        end
    end

    // Register clear strobes for the data and index register file
    wire [`LLE_NUM_REG-1:0] reg_clr_nxt =
        !is_clr            ? '0 :
        (ot == LLE_OT_D)   ? `LLE_NUM_REG'(1) << instr.addr[2:0] :
        (ot == LLE_OT_A)   ? `LLE_NUM_REG'(1) << `LLE_REG_A_IDX :
        (ot == LLE_OT_B)   ? `LLE_NUM_REG'(1) << `LLE_REG_B_IDX : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_clr_r <= '0;
        end else begin
            reg_clr_r <= reg_clr_nxt;
        end
    end
endmodule : lle_executor

// file: testbench/lle_exec_asserts.sv
// Port-level assertions for the ladder logic executor
`timescale 1ns/1ps
`include "lle_defines.svh"
module lle_exec_asserts #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic                     clock,
    input wire logic                     rst,
    input wire lle_pkg::lle_instr_type   instr,
    input wire logic [15:0]              x_in,
    input wire logic                     in_handler,
    input wire logic [`LLE_PC_W-1:0]     pc_r,
    input wire logic [15:0]              y_out_r,
    input wire logic [`LLE_NUM_BITS-1:0] pulse_r,
    input wire logic [`LLE_NUM_REG-1:0]  reg_clr_r,
    input wire logic                     stack_err_r
);
    import lle_pkg::*;
    // One clock domain, reset disables every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Step sequencing and output image timing
    chk_end_restart: assert property (instr.op == LLE_OP_END |=> pc_r == 8'h00)
        else $error("step not zero after end");
    chk_pc_advance: assert property (!in_handler && instr.op != LLE_OP_END
        |=> pc_r == $past(pc_r) + 8'h01)
        else $error("step did not advance by one");
    chk_handler_freeze: assert property (in_handler && instr.op != LLE_OP_END |=> $stable(pc_r))
        else $error("step moved inside handler");
    chk_outputs_end_only: assert property (instr.op != LLE_OP_END |=> $stable(y_out_r))
        else $error("outputs changed outside end");
    // Stack fault flag
    chk_err_sticky: assert property (stack_err_r |=> stack_err_r)
        else $error("stack fault flag dropped");
    chk_err_cause: assert property ($rose(stack_err_r)
        |-> $past(instr.op) inside {LLE_OP_PUSH, LLE_OP_PEEK, LLE_OP_POP})
        else $error("stack fault without stack operation");
    // Register clear pulses
    chk_clr_only_clear: assert property (instr.op != LLE_OP_CLR |=> reg_clr_r == 10'h000)
        else $error("register clear without clear operation");
    // New pulse bits only come from a bit write
    chk_pulse_cause: assert property ((pulse_r & ~$past(pulse_r)) != '0
        |-> $past(instr.op) inside {LLE_OP_COIL, LLE_OP_SET})
        else $error("pulse set without bit write");
endmodule : lle_exec_asserts

// file: testbench/test_ladder_logic_executor.sv
// Self-checking bench for the ladder logic executor
`timescale 1ns/1ps
module test_ladder_logic_executor;
    import lle_pkg::*;
    logic          clock      = 1'b0;
    logic          rst        = 1'b1;
    lle_instr_type instr      = '0;
    logic [15:0]   x_in       = 16'h0000;
    logic          in_handler = 1'b0;
    logic [7:0]    pc_r;
    logic [15:0]   y_out_r;
    logic [47:0]   pulse_r;
    logic [9:0]    reg_clr_r;
    logic          stack_err_r;
    int            n_errors   = 0;
    int            tests_run  = 0;
    lle_instr_type prg[$];
    // 25 MHz clock
    always #20 clock = ~clock;
    lle_executor #(.TICK_CYCLES(10)) lle_executor_inst (.clock(clock), .rst(rst),
        .instr(instr), .x_in(x_in), .in_handler(in_handler), .pc_r(pc_r), .y_out_r(y_out_r),
        .pulse_r(pulse_r), .reg_clr_r(reg_clr_r), .stack_err_r(stack_err_r));
    // Compare and count
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic lle_instr_type ins(lle_op_type o, lle_otype_type t = LLE_OT_X,
        int a = 0, logic [31:0] k = 32'h0000_0000, logic d = 1'b0);
        return '{o, d, t, a[4:0], k};
    endfunction : ins
    // Present one instruction for one edge; called and returns at a falling edge
    task automatic step(input lle_instr_type i);
        instr = i;
        @(negedge clock);
    endtask : step
    // Run the program list, then end of program
    task automatic scan();
        foreach (prg[i]) step(prg[i]);
        step(ins(LLE_OP_END));
        check(pc_r, 8'h00);
    endtask : scan
    task automatic test_join();
        x_in = 16'h0002;
        prg = '{ins(LLE_OP_BEGIN), ins(LLE_OP_BEGIN, LLE_OT_X, 1), ins(LLE_OP_JOIN),
            ins(LLE_OP_COIL, LLE_OT_Y, 0), ins(LLE_OP_BEGIN, LLE_OT_X, 1),
            ins(LLE_OP_BEGIN, LLE_OT_X, 2),
            ins(LLE_OP_JOIN), ins(LLE_OP_COIL, LLE_OT_Y, 1), ins(LLE_OP_BEGNI),
            ins(LLE_OP_COIL, LLE_OT_Y, 2)};
        scan();
        check(y_out_r[2:0], 3'h7);
        $display("test_join done");
    endtask : test_join
    task automatic test_stack();
        x_in = 16'h0001;
        prg = '{ins(LLE_OP_BEGIN), ins(LLE_OP_PUSH), ins(LLE_OP_BEGIN, LLE_OT_X, 1),
            ins(LLE_OP_COIL, LLE_OT_Y, 3), ins(LLE_OP_PEEK), ins(LLE_OP_COIL, LLE_OT_Y, 4),
            ins(LLE_OP_COIL, LLE_OT_Y, 5), ins(LLE_OP_BEGNI), ins(LLE_OP_POP),
            ins(LLE_OP_COIL, LLE_OT_M, 6), ins(LLE_OP_BEGIN, LLE_OT_M, 6),
            ins(LLE_OP_COIL, LLE_OT_Y, 7)};
        scan();
        check(y_out_r[7:3], 5'h16);
        check(stack_err_r, 1'b0);
        $display("test_stack done");
    endtask : test_stack
    task automatic test_latch();
        prg = '{ins(LLE_OP_BEGIN), ins(LLE_OP_SET, LLE_OT_Y, 8)};
        scan();
        check(y_out_r[8], 1'b1);
        x_in = 16'h0000;
        scan();
        check(y_out_r[8], 1'b1);
        step(ins(LLE_OP_BEGNI));
        step(ins(LLE_OP_CLR, LLE_OT_D, 3));
        check(reg_clr_r, 10'h008);
        step(ins(LLE_OP_CLR, LLE_OT_B));
        check(reg_clr_r, 10'h200);
        prg = '{ins(LLE_OP_BEGNI), ins(LLE_OP_CLR, LLE_OT_Y, 8)};
        scan();
        check(y_out_r[8], 1'b0);
        x_in = 16'h0001;
        scan();
        check(y_out_r[8], 1'b0);
        $display("test_latch done");
    endtask : test_latch
    task automatic test_timer();
        prg = '{ins(LLE_OP_BEGIN), ins(LLE_OP_TMR, LLE_OT_T, 1, 32'h0000_0003),
            ins(LLE_OP_BEGIN, LLE_OT_T, 1), ins(LLE_OP_COIL, LLE_OT_Y, 9)};
        scan();
        scan();
        check(y_out_r[9], 1'b0);
        for (int n = 0; n < 12 && y_out_r[9] !== 1'b1; n++) scan();
        check(y_out_r[9], 1'b1);
        x_in = 16'h0000;
        scan();
        check(y_out_r[9], 1'b0);
        x_in = 16'h0001;
        scan();
        check(y_out_r[9], 1'b0);
        $display("test_timer done");
    endtask : test_timer
    task automatic test_tally();
        prg = '{ins(LLE_OP_BEGIN), ins(LLE_OP_TALLY, LLE_OT_C, 2, 32'h0000_0002),
            ins(LLE_OP_BEGIN, LLE_OT_C, 2), ins(LLE_OP_COIL, LLE_OT_Y, 10), ins(LLE_OP_BEGIN),
            ins(LLE_OP_TALLY, LLE_OT_C, 3, 32'h0001_0001), ins(LLE_OP_BEGIN, LLE_OT_C, 3),
            ins(LLE_OP_COIL, LLE_OT_Y, 11), ins(LLE_OP_BEGIN),
            ins(LLE_OP_TALLY, LLE_OT_C, 4, 32'h0001_0001, 1'b1),
            ins(LLE_OP_BEGIN, LLE_OT_C, 4), ins(LLE_OP_COIL, LLE_OT_Y, 12)};
        x_in = 16'h0000;
        scan();
        x_in = 16'h0001;
        scan();
        scan();
        check(y_out_r[12:10], 3'h2);
        x_in = 16'h0000;
        scan();
        x_in = 16'h0001;
        scan();
        check(y_out_r[12:10], 3'h3);
        prg = '{ins(LLE_OP_BEGIN), ins(LLE_OP_CLR, LLE_OT_C, 2),
            ins(LLE_OP_BEGIN, LLE_OT_C, 2), ins(LLE_OP_COIL, LLE_OT_Y, 10)};
        scan();
        check(y_out_r[10], 1'b0);
        $display("test_tally done");
    endtask : test_tally
    task automatic test_pulse();
        prg = '{ins(LLE_OP_NOP), ins(LLE_OP_BEGIN), ins(LLE_OP_COIL, LLE_OT_Y, 13)};
        scan();
        check(pulse_r[13], 1'b1);
        step(ins(LLE_OP_NOP));
        check(pulse_r[13], 1'b1);
        step(ins(LLE_OP_BEGIN));
        check(pulse_r[13], 1'b1);
        in_handler = 1'b1;
        step(ins(LLE_OP_NOP));
        check({pc_r, pulse_r[13]}, 9'h005);
        in_handler = 1'b0;
        step(ins(LLE_OP_COIL, LLE_OT_Y, 13));
        check(pulse_r[13], 1'b0);
        $display("test_pulse done");
    endtask : test_pulse
    task automatic test_stack_err();
        step(ins(LLE_OP_END));
        repeat (8) step(ins(LLE_OP_PUSH));
        check(stack_err_r, 1'b0);
        step(ins(LLE_OP_PUSH));
        check(stack_err_r, 1'b1);
        $display("test_stack_err done");
    endtask : test_stack_err
    // Report and end the run
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        test_join();
        test_stack();
        test_latch();
        test_timer();
        test_tally();
        test_pulse();
        test_stack_err();
        stop_test();
    end
endmodule : test_ladder_logic_executor
bind lle_executor lle_exec_asserts #(.TICK_CYCLES(TICK_CYCLES)) lle_exec_asserts_inst (
    .clock(clock), .rst(rst), .instr(instr), .x_in(x_in), .in_handler(in_handler),
    .pc_r(pc_r), .y_out_r(y_out_r), .pulse_r(pulse_r), .reg_clr_r(reg_clr_r),
    .stack_err_r(stack_err_r));
